// [host_port_pkg.sv]
`default_nettype none
package host_port_pkg;
   // ===========================================================
   // Clocking and bit-rate arithmetic
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned MCLK_KHZ = 10000;
   localparam int unsigned REF_KHZ = 27120;
   localparam int unsigned FRAC_SCALE = 1000;
   localparam int DIV_W = 13;
   localparam int ACC_W = 24;
   localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(REF_KHZ * FRAC_SCALE / MCLK_KHZ);
   localparam logic [ACC_W-1:0] FRAC_SCALE_W = ACC_W'(FRAC_SCALE);

   // ===========================================================
   // Spike suppression on the two-wire inputs
   localparam int unsigned SPIKE_NS = 50;
   localparam int unsigned SPIKE_CYCLES =
      (SPIKE_NS / CLK_PERIOD_NS) < 1 ? 1 : SPIKE_NS / CLK_PERIOD_NS;
   localparam logic [1:0] SPIKE_LAST = 2'(SPIKE_CYCLES);

   // ===========================================================
   // Serial rate register layout
   localparam logic [7:0] RATE_RESET = 8'h7A;
   localparam int RATE_EXP_MSB = 7;
   localparam int RATE_EXP_LSB = 5;
   localparam int RATE_MAN_MSB = 4;
   localparam int RATE_MAN_LSB = 0;
   localparam logic [DIV_W-1:0] MAN_OFFSET_LOW = 13'h0001;
   localparam logic [DIV_W-1:0] MAN_OFFSET_HIGH = 13'h0021;

   // ===========================================================
   // Register map seen by the host
   localparam logic [6:0] RATE_REG_ADDR = 7'h7F;
   localparam logic [6:0] FIFO_REG_ADDR = 7'h05;

   // ===========================================================
   // Interface straps and two-wire addressing
   localparam logic [1:0] IFSEL_UART = 2'h0;
   localparam logic [1:0] IFSEL_I2C = 2'h1;
   localparam logic [4:0] I2C_ADDR_HIGH = 5'h0A;
   localparam logic [6:0] I2C_GENERAL_CALL = 7'h00;
   localparam logic [6:0] I2C_DEVICE_ID = 7'h7C;
   localparam logic [3:0] I2C_ACK_BIT = 4'h8;
   localparam logic [3:0] I2C_ACK_DONE = 4'h9;
   localparam logic [2:0] UART_LAST_DATA = 3'h7;
   localparam logic [3:0] UART_LAST_SHIFT = 4'h9;

   typedef enum logic [1:0]
   {
      RX_IDLE = 2'h0,
      RX_START = 2'h1,
      RX_DATA = 2'h3,
      RX_STOP = 2'h2
   } uart_rx_state_type;

   typedef enum logic [1:0]
   {
      I2C_IDLE = 2'h0,
      I2C_ADDR = 2'h1,
      I2C_WRITE = 2'h3,
      I2C_READ = 2'h2
   } i2c_state_type;

   // ===========================================================
   // Divider in reference-clock periods per bit
   function automatic logic [DIV_W-1:0] rate_divisor(input logic [7:0] rate);
      logic [2:0] expo;
      logic [DIV_W-1:0] mant;
      expo = rate[RATE_EXP_MSB:RATE_EXP_LSB];
      mant = DIV_W'(rate[RATE_MAN_MSB:RATE_MAN_LSB]);
      if (expo == 3'h0)
         rate_divisor = mant + MAN_OFFSET_LOW;
      else
         rate_divisor = (mant + MAN_OFFSET_HIGH) << (expo - 3'h1);
   endfunction : rate_divisor

   // Pointer advance; the FIFO location is never left
   function automatic logic [6:0] next_ptr(input logic [6:0] ptr);
      next_ptr = (ptr == FIFO_REG_ADDR) ? ptr : ptr + 7'h01;
   endfunction : next_ptr
endpackage : host_port_pkg
`default_nettype wire

// [rate_tick_gen.sv]
`default_nettype none
module rate_tick_gen #(
   parameter int ACC_W = host_port_pkg::ACC_W,
   parameter int DIV_W = host_port_pkg::DIV_W
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic restart,
   input wire logic half_start,
   input wire logic [DIV_W-1:0] divisor,
   output logic tick
);
   // ===========================================================
   // Fractional accumulator: mclk is not a multiple of the reference,
   // so each bit is up to one cycle long or short; jitter stays under
   // one mclk period
   logic [ACC_W-1:0] acc_q, acc_d, full_len, sum;
   logic tick_q, tick_d;

   always_comb
   begin
      full_len = ACC_W'(divisor) * host_port_pkg::FRAC_SCALE_W;
      sum = acc_q + host_port_pkg::ACC_STEP;
      acc_d = sum;
      tick_d = 1'b0;
      if (restart)
         acc_d = half_start ? (full_len >> 1) : '0;
      else if (sum >= full_len)
      begin
         acc_d = sum - full_len;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_q <= '0;
         tick_q <= 1'b0;
      end
      else if (clk_en)
      begin
         acc_q <= acc_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule : rate_tick_gen
`default_nettype wire

// [host_port.sv]
// Summary of operation
// - UART runs 115.2 kbit/s after reset
// - Host sets rate via rate register fields
// - Rate is reference over mantissa and exponent
// - Exponent 0..7 gives factors 1,1,2..64
// - Character is start, eight data, stop
// - UART bytes travel least significant first
// - Read: address byte in, data byte out when read_trigger_pin is high
// - Write: address then data, address echoed
// - Data byte accepted during echo
// - Two-wire port is slave only
// - Clock line is never held low
// - General call address is ignored
// - No device-ID answer, no high speed
// - Spike filter on both lines in two-wire mode
// - Data changes with clock low; start/stop detected
// - Bytes MSB first, receiver drives acknowledge
// - Master NACK makes device release data
// - Slave address 01010 plus two select bits
// - Write frame: address, register, data bytes
// - FIFO address never advances
// - Other addresses advance per byte
// - Read frame continues from set pointer
`default_nettype none
module host_port
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [1:0] if_sel_pins,
   input wire logic uart_rx_pin,
   output logic uart_tx_pin,
   input wire logic read_trigger_pin,
   input wire logic scl_pin,
   input wire logic sda_in_pin,
   output logic sda_out_pin,
   output logic sda_oe_n,
   input wire logic [1:0] adr_pins,
   input wire logic [1:0] nv_adr,
   input wire logic nv_adr_use,
   output logic [6:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   // ===========================================================
   // Synchronisers for every pin
   logic [7:0] pins_in, meta_q, sync_q;
   logic rx_s, trig_s, scl_s, sda_s;

   assign pins_in = {if_sel_pins, adr_pins, sda_in_pin, scl_pin, read_trigger_pin, uart_rx_pin};

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= 8'hFF;
         sync_q <= 8'hFF;
      end
      else if (clk_en)
      begin
         meta_q <= pins_in;
         sync_q <= meta_q;
      end
   end

   assign rx_s = sync_q[0];
   assign trig_s = sync_q[1];
   assign scl_s = sync_q[2];
   assign sda_s = sync_q[3];

   // ===========================================================
   // Strap capture and spike filter
   logic [1:0] mode_q, mode_d, strap_cnt_q, strap_cnt_d;
   logic mode_ok_q, mode_ok_d, uart_sel, i2c_sel;
   logic [1:0] flt_q, flt_d, raw;
   logic [1:0] fcnt_q [2];
   logic [1:0] fcnt_d [2];

   assign raw = {sda_s, scl_s};
   assign uart_sel = mode_ok_q && (mode_q == host_port_pkg::IFSEL_UART);
   assign i2c_sel = mode_ok_q && (mode_q == host_port_pkg::IFSEL_I2C);

   always_comb
   begin
      mode_d = mode_q;
      mode_ok_d = mode_ok_q;
      strap_cnt_d = strap_cnt_q;
      // Straps are read once the synchronisers hold settled values
      if (!mode_ok_q)
      begin
         strap_cnt_d = strap_cnt_q + 2'h1;
         if (strap_cnt_q == 2'h3)
         begin
            mode_d = sync_q[7:6];
            mode_ok_d = 1'b1;
         end
      end
      for (int i = 0; i < 2; i++)
      begin
         flt_d[i] = flt_q[i];
         fcnt_d[i] = 2'h0;
         if (!i2c_sel || raw[i] == flt_q[i])
            flt_d[i] = raw[i];
         else if (fcnt_q[i] == host_port_pkg::SPIKE_LAST)
            flt_d[i] = raw[i];
         else
            fcnt_d[i] = fcnt_q[i] + 2'h1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q <= 2'h0;
         mode_ok_q <= 1'b0;
         strap_cnt_q <= 2'h0;
         flt_q <= 2'h3;
         fcnt_q <= '{2'h0, 2'h0};
      end
      else if (clk_en)
      begin
         mode_q <= mode_d;
         mode_ok_q <= mode_ok_d;
         strap_cnt_q <= strap_cnt_d;
         flt_q <= flt_d;
         fcnt_q <= fcnt_d;
      end
   end

   // ===========================================================
   // Register port and serial rate register
   logic u_rd, u_wr, i_rd, i_wr, req_rd, req_wr;
   logic [6:0] u_addr, i_addr, req_addr, reg_addr_d;
   logic [7:0] u_wdata, i_wdata, req_wdata, reg_wdata_d, rate_q, rate_d, rd_data;
   logic reg_wr_d, reg_rd_d, rd_done;
   logic [1:0] rd_stage_q, rd_stage_d;
   logic [host_port_pkg::DIV_W-1:0] divisor;

   assign req_rd = uart_sel ? u_rd : i_rd;
   assign req_wr = uart_sel ? u_wr : i_wr;
   assign req_addr = uart_sel ? u_addr : i_addr;
   assign req_wdata = uart_sel ? u_wdata : i_wdata;
   assign rd_done = rd_stage_q[1];
   assign rd_data = (reg_addr == host_port_pkg::RATE_REG_ADDR) ? rate_q : reg_rdata;
   assign divisor = host_port_pkg::rate_divisor(rate_q);

   always_comb
   begin
      reg_addr_d = reg_addr;
      reg_wdata_d = reg_wdata;
      rate_d = rate_q;
      if (req_rd || req_wr)
         reg_addr_d = req_addr;
      if (req_wr)
         reg_wdata_d = req_wdata;
      reg_wr_d = req_wr && (req_addr != host_port_pkg::RATE_REG_ADDR);
      reg_rd_d = req_rd && (req_addr != host_port_pkg::RATE_REG_ADDR);
      if (req_wr && req_addr == host_port_pkg::RATE_REG_ADDR)
         rate_d = req_wdata;
      // Read data is taken one cycle after the strobe
      rd_stage_d = {rd_stage_q[0], req_rd};
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_addr <= 7'h00;
         reg_wdata <= 8'h00;
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
         rate_q <= host_port_pkg::RATE_RESET;
         rd_stage_q <= 2'h0;
      end
      else if (clk_en)
      begin
         reg_addr <= reg_addr_d;
         reg_wdata <= reg_wdata_d;
         reg_wr <= reg_wr_d;
         reg_rd <= reg_rd_d;
         rate_q <= rate_d;
         rd_stage_q <= rd_stage_d;
      end
   end

   // ===========================================================
   // UART receiver, transmitter and transaction control
   host_port_pkg::uart_rx_state_type rx_state_q, rx_state_d;
   logic [2:0] rx_bits_q, rx_bits_d;
   logic [7:0] rx_shift_q, rx_shift_d, tx_byte;
   logic [6:0] uart_addr_q, uart_addr_d;
   logic wr_pend_q, wr_pend_d, rx_restart, rx_tick, byte_done;
   logic [9:0] tx_shift_q, tx_shift_d;
   logic [3:0] tx_cnt_q, tx_cnt_d;
   logic tx_busy_q, tx_busy_d, tx_q, tx_restart, tx_tick, tx_start;

   rate_tick_gen rx_gen
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .restart(rx_restart),
      .half_start(1'b1),
      .divisor(divisor),
      .tick(rx_tick)
   );

   rate_tick_gen tx_gen
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .restart(tx_restart),
      .half_start(1'b0),
      .divisor(divisor),
      .tick(tx_tick)
   );

   assign u_addr = wr_pend_q ? uart_addr_q : rx_shift_q[7:1];
   assign u_wdata = rx_shift_q;

   always_comb
   begin
      rx_state_d = rx_state_q;
      rx_bits_d = rx_bits_q;
      rx_shift_d = rx_shift_q;
      uart_addr_d = uart_addr_q;
      wr_pend_d = wr_pend_q;
      rx_restart = 1'b0;
      byte_done = 1'b0;
      u_rd = 1'b0;
      u_wr = 1'b0;
      tx_start = 1'b0;
      tx_byte = rx_shift_q;
      unique case (rx_state_q)
         host_port_pkg::RX_IDLE:
            if (uart_sel && !rx_s)
            begin
               rx_restart = 1'b1;
               rx_state_d = host_port_pkg::RX_START;
            end
         host_port_pkg::RX_START:
            if (rx_tick)
            begin
               rx_bits_d = 3'h0;
               rx_state_d = rx_s ? host_port_pkg::RX_IDLE : host_port_pkg::RX_DATA;
            end
         host_port_pkg::RX_DATA:
            if (rx_tick)
            begin
               rx_shift_d = {rx_s, rx_shift_q[7:1]};
               rx_bits_d = rx_bits_q + 3'h1;
               if (rx_bits_q == host_port_pkg::UART_LAST_DATA)
                  rx_state_d = host_port_pkg::RX_STOP;
            end
         host_port_pkg::RX_STOP:
            if (rx_tick)
            begin
               rx_state_d = host_port_pkg::RX_IDLE;
               byte_done = rx_s;
            end
      endcase
      if (byte_done)
      begin
         if (wr_pend_q)
         begin
            u_wr = 1'b1;
            wr_pend_d = 1'b0;
         end
         else if (rx_shift_q[0])
            u_rd = trig_s;
         else
         begin
            uart_addr_d = rx_shift_q[7:1];
            wr_pend_d = 1'b1;
            tx_start = 1'b1;
         end
      end
      if (uart_sel && rd_done)
      begin
         tx_start = 1'b1;
         tx_byte = rd_data;
      end
      tx_shift_d = tx_shift_q;
      tx_cnt_d = tx_cnt_q;
      tx_busy_d = tx_busy_q;
      tx_restart = 1'b0;
      // A start while busy is dropped; the protocol never overlaps two answers
      if (!tx_busy_q && tx_start)
      begin
         tx_shift_d = {1'b1, tx_byte, 1'b0};
         tx_cnt_d = 4'h0;
         tx_busy_d = 1'b1;
         tx_restart = 1'b1;
      end
      else if (tx_busy_q && tx_tick)
      begin
         tx_shift_d = {1'b1, tx_shift_q[9:1]};
         tx_cnt_d = tx_cnt_q + 4'h1;
         if (tx_cnt_q == host_port_pkg::UART_LAST_SHIFT)
            tx_busy_d = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_state_q <= host_port_pkg::RX_IDLE;
         rx_bits_q <= 3'h0;
         rx_shift_q <= 8'h00;
         uart_addr_q <= 7'h00;
         wr_pend_q <= 1'b0;
         tx_shift_q <= 10'h3FF;
         tx_cnt_q <= 4'h0;
         tx_busy_q <= 1'b0;
         tx_q <= 1'b1;
      end
      else if (clk_en)
      begin
         rx_state_q <= rx_state_d;
         rx_bits_q <= rx_bits_d;
         rx_shift_q <= rx_shift_d;
         uart_addr_q <= uart_addr_d;
         wr_pend_q <= wr_pend_d;
         tx_shift_q <= tx_shift_d;
         tx_cnt_q <= tx_cnt_d;
         tx_busy_q <= tx_busy_d;
         tx_q <= tx_shift_d[0];
      end
   end

   assign uart_tx_pin = tx_q;

   // ===========================================================
   // Two-wire slave; the clock line is input only, so no stretching
   host_port_pkg::i2c_state_type i2c_state_q, i2c_state_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] i_shift_q, i_shift_d, txd_q, txd_d, txd_sh;
   logic [6:0] ptr_q, ptr_d, my_addr;
   logic scl_f, sda_f, scl_p_q, sda_p_q, first_q, first_d, acked_q, acked_d;
   logic oe_n_q, oe_n_d, sda_out_q, start_c, stop_c, rise, fall;

   assign scl_f = flt_q[0];
   assign sda_f = flt_q[1];
   assign my_addr = {host_port_pkg::I2C_ADDR_HIGH, nv_adr_use ? nv_adr : sync_q[5:4]};
   assign start_c = scl_f && scl_p_q && sda_p_q && !sda_f;
   assign stop_c = scl_f && scl_p_q && !sda_p_q && sda_f;
   assign rise = scl_f && !scl_p_q;
   assign fall = !scl_f && scl_p_q;
   assign txd_sh = txd_q << bit_q[2:0];
   assign i_addr = ptr_q;
   assign i_wdata = i_shift_q;

   always_comb
   begin
      i2c_state_d = i2c_state_q;
      bit_d = bit_q;
      i_shift_d = i_shift_q;
      txd_d = txd_q;
      ptr_d = ptr_q;
      first_d = first_q;
      acked_d = acked_q;
      oe_n_d = oe_n_q;
      i_rd = 1'b0;
      i_wr = 1'b0;
      if (!i2c_sel || stop_c)
      begin
         i2c_state_d = host_port_pkg::I2C_IDLE;
         oe_n_d = 1'b1;
      end
      else if (start_c)
      begin
         i2c_state_d = host_port_pkg::I2C_ADDR;
         bit_d = 4'h0;
         oe_n_d = 1'b1;
      end
      else if (i2c_state_q != host_port_pkg::I2C_IDLE)
      begin
         if (rise)
         begin
            if (bit_q < host_port_pkg::I2C_ACK_BIT)
               i_shift_d = {i_shift_q[6:0], sda_f};
            else
               acked_d = !sda_f;
            bit_d = bit_q + 4'h1;
         end
         if (fall && bit_q == host_port_pkg::I2C_ACK_BIT)
         begin
            unique case (i2c_state_q)
               host_port_pkg::I2C_ADDR:
                  if (i_shift_q[7:1] == my_addr
                      && i_shift_q[7:1] != host_port_pkg::I2C_GENERAL_CALL
                      && i_shift_q[7:1] != host_port_pkg::I2C_DEVICE_ID)
                  begin
                     oe_n_d = 1'b0;
                     first_d = 1'b1;
                     i2c_state_d = i_shift_q[0] ? host_port_pkg::I2C_READ
                                                : host_port_pkg::I2C_WRITE;
                  end
                  else
                     i2c_state_d = host_port_pkg::I2C_IDLE;
               host_port_pkg::I2C_WRITE:
               begin
                  oe_n_d = 1'b0;
                  first_d = 1'b0;
                  if (first_q)
                     ptr_d = i_shift_q[6:0];
                  else
                  begin
                     i_wr = 1'b1;
                     ptr_d = host_port_pkg::next_ptr(ptr_q);
                  end
               end
               host_port_pkg::I2C_READ:
                  oe_n_d = 1'b1;
               default:
                  oe_n_d = 1'b1;
            endcase
         end
         else if (fall && bit_q == host_port_pkg::I2C_ACK_DONE)
         begin
            bit_d = 4'h0;
            oe_n_d = 1'b1;
            if (i2c_state_q == host_port_pkg::I2C_READ)
            begin
               if (acked_q)
               begin
                  i_rd = 1'b1;
                  ptr_d = host_port_pkg::next_ptr(ptr_q);
               end
               else
                  i2c_state_d = host_port_pkg::I2C_IDLE;
            end
         end
         else if (fall && i2c_state_q == host_port_pkg::I2C_READ && bit_q != 4'h0
                  && bit_q < host_port_pkg::I2C_ACK_BIT)
            oe_n_d = txd_sh[7];
      end
      // Fetched byte drives its MSB while the clock is still low
      if (rd_done && i2c_sel && i2c_state_q == host_port_pkg::I2C_READ)
      begin
         txd_d = rd_data;
         oe_n_d = rd_data[7];
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         i2c_state_q <= host_port_pkg::I2C_IDLE;
         bit_q <= 4'h0;
         i_shift_q <= 8'h00;
         txd_q <= 8'h00;
         ptr_q <= 7'h00;
         first_q <= 1'b0;
         acked_q <= 1'b0;
         oe_n_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         sda_out_q <= 1'b0;
      end
      else if (clk_en)
      begin
         i2c_state_q <= i2c_state_d;
         bit_q <= bit_d;
         i_shift_q <= i_shift_d;
         txd_q <= txd_d;
         ptr_q <= ptr_d;
         first_q <= first_d;
         acked_q <= acked_d;
         oe_n_q <= oe_n_d;
         scl_p_q <= scl_f;
         sda_p_q <= sda_f;
         sda_out_q <= 1'b0;
      end
   end

   assign sda_out_pin = sda_out_q;
   assign sda_oe_n = oe_n_q;
endmodule : host_port
`default_nettype wire

// [host_port_props.sv]
`default_nettype none
module host_port_props
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [1:0] if_sel_pins,
   input wire logic uart_tx_pin,
   input wire logic read_trigger_pin,
   input wire logic scl_pin,
   input wire logic sda_out_pin,
   input wire logic sda_oe_n,
   input wire logic [6:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // ==========
   // Character shape; 7 clocks, since the fastest bit the test sets (rate 8'h15) is 8 or 9
   sequence s_low_bit;
      !uart_tx_pin [*7];
   endsequence
   sequence s_high_bit;
      uart_tx_pin [*7];
   endsequence
   AST_TX_LOW_BIT: assert property ($fell(uart_tx_pin) |-> s_low_bit)
      else $error("Transmit low level too short");
   AST_TX_HIGH_BIT: assert property ($rose(uart_tx_pin) |-> s_high_bit)
      else $error("Transmit high level too short");
   AST_IDLE_AFTER_RESET: assert property ($rose(rst_n) |-> uart_tx_pin && sda_oe_n)
      else $error("Lines not idle after reset");
   // ==========
   // Register strobes
   AST_READ_NEEDS_TRIGGER: assert property (reg_rd && if_sel_pins == 2'h0 |-> read_trigger_pin)
      else $error("Serial read without trigger");
   AST_RATE_STAYS_INSIDE: assert property (reg_wr || reg_rd |-> reg_addr != 7'h7F)
      else $error("Rate register access left the port");
   AST_WR_PULSE: assert property (reg_wr |=> !reg_wr && !reg_rd)
      else $error("Write strobe longer than one clock");
   AST_RD_PULSE: assert property (reg_rd |=> !reg_rd)
      else $error("Read strobe longer than one clock");
   // ==========
   // Two-wire data line
   AST_OD_LOW_ONLY: assert property (sda_out_pin == 1'h0)
      else $error("Data line driven high");
   AST_SDA_WITH_SCL_LOW: assert property ($changed(sda_oe_n) |-> !$past(scl_pin))
      else $error("Data line changed with clock high");
   AST_UART_NO_SDA: assert property (if_sel_pins == 2'h0 |-> sda_oe_n)
      else $error("Data line driven in serial mode");
endmodule : host_port_props
bind host_port host_port_props u_host_port_props (.*);
`default_nettype wire

// [host_model.sv]
`default_nettype none
module host_model
(
   input wire logic uart_tx_pin,
   input wire logic sda_oe_n,
   output logic uart_rx_pin,
   output logic scl_pin,
   output logic sda_in_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Host side of both links
   int bit_ns;
   logic pull;
   // Pulled-up wire, low when either side pulls
   assign sda_in_pin = !pull && sda_oe_n;
   initial
   begin
      bit_ns = 8702;
      uart_rx_pin = 1'h1;
      scl_pin = 1'h1;
      pull = 1'h0;
   end
   task automatic uart_send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'h1, b, 1'h0};
      for (int i = 0; i < 10; i++)
      begin
         uart_rx_pin = f[i];
         #(bit_ns);
      end
   endtask : uart_send
   // Bit 8 of the result is the stop level; all zero when nothing came
   task automatic uart_recv(output logic [8:0] r);
      int n = 0;
      r = '0;
      while (uart_tx_pin && n < 3000)
      begin
         #100;
         n++;
      end
      if (n < 3000)
      begin
         #(bit_ns + bit_ns / 2);
         for (int i = 0; i < 9; i++)
         begin
            r[i] = uart_tx_pin;
            #(bit_ns);
         end
      end
   endtask : uart_recv
   task automatic i2c_bit(input logic v, output logic r);
      #400 pull = !v;
      #300 scl_pin = 1'h1;
      #200 r = sda_in_pin;
      #100 scl_pin = 1'h0;
   endtask : i2c_bit
   task automatic i2c_start;
      #300 pull = 1'h0;
      #300 scl_pin = 1'h1;
      #300 pull = 1'h1;
      #300 scl_pin = 1'h0;
   endtask : i2c_start
   task automatic i2c_stop;
      #300 pull = 1'h1;
      #300 scl_pin = 1'h1;
      #300 pull = 1'h0;
      #300;
   endtask : i2c_stop
   task automatic i2c_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         i2c_bit(b[i], r);
      i2c_bit(1'h1, r);
      ack = !r;
   endtask : i2c_byte
   task automatic i2c_read(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
         i2c_bit(1'h1, b[i]);
      i2c_bit(last, r);
   endtask : i2c_read
endmodule : host_model
`default_nettype wire

// [host_port_tb.sv]
`default_nettype none
module host_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, rst_n, read_trigger_pin, nv_adr_use;
   logic [1:0] if_sel_pins, adr_pins, nv_adr;
   logic uart_rx_pin, uart_tx_pin, scl_pin, sda_in_pin, sda_oe_n, reg_wr, reg_rd;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [14:0] wr_q[$];
   int rd_cnt, error_cnt, check_count;
   // ==========
   // Clock, design, host
   initial mclk = 1'h0;
   always #50 mclk = ~mclk;
   host_port u_host_port
   (
      .mclk(mclk), .rst_n(rst_n), .clk_en(1'h1), .if_sel_pins(if_sel_pins),
      .uart_rx_pin(uart_rx_pin), .uart_tx_pin(uart_tx_pin),
      .read_trigger_pin(read_trigger_pin), .scl_pin(scl_pin), .sda_in_pin(sda_in_pin),
      .sda_out_pin(), .sda_oe_n(sda_oe_n), .adr_pins(adr_pins), .nv_adr(nv_adr),
      .nv_adr_use(nv_adr_use), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
   );
   host_model u_host_model
   (
      .uart_tx_pin(uart_tx_pin), .sda_oe_n(sda_oe_n), .uart_rx_pin(uart_rx_pin),
      .scl_pin(scl_pin), .sda_in_pin(sda_in_pin)
   );
   function automatic logic [7:0] rd_val(input logic [6:0] a);
      rd_val = {a, 1'h1} ^ 8'h3C;
   endfunction : rd_val
   assign reg_rdata = rd_val(reg_addr);
   always @(posedge mclk)
   begin
      if (reg_wr === 1'h1)
         wr_q.push_back({reg_addr, reg_wdata});
      if (reg_rd === 1'h1)
         rd_cnt++;
   end
   // ==========
   // Shared steps
   task automatic chk(input string what, input logic [29:0] exp, input logic [29:0] got);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic do_reset(input logic [1:0] sel);
      rst_n = 1'h0;
      if_sel_pins = sel;
      u_host_model.bit_ns = 8702;
      repeat (20) @(negedge mclk);
      rst_n = 1'h1;
      repeat (10) @(negedge mclk);
   endtask : do_reset
   // ==========
   // Scenarios
   task automatic t_uart_write(input logic [7:0] a, input logic [7:0] d, input int n);
      logic [8:0] e;
      wr_q.delete();
      @(negedge mclk);
      fork
         begin
            u_host_model.uart_send(a);
            u_host_model.uart_send(d);
         end
         u_host_model.uart_recv(e);
      join
      chk("echo", {1'h1, a}, e);
      chk("writes", 15'(n), 15'(wr_q.size()));
      if (n > 0)
         chk("write", {a[7:1], d}, wr_q[0]);
   endtask : t_uart_write
   task automatic t_uart_read(input logic t, input logic [7:0] a, input logic [8:0] x, int n);
      logic [8:0] d;
      int r0 = rd_cnt;
      @(negedge mclk);
      read_trigger_pin = t;
      fork
         u_host_model.uart_send(a);
         u_host_model.uart_recv(d);
      join
      @(negedge mclk);
      read_trigger_pin = 1'h0;
      chk("read", x, d);
      chk("reads", 15'(n), 15'(rd_cnt - r0));
   endtask : t_uart_read
   task automatic t_i2c_addr(input logic [7:0] a, input logic x);
      logic ack;
      u_host_model.i2c_start();
      u_host_model.i2c_byte(a, ack);
      u_host_model.i2c_stop();
      chk("ack", 15'(x), 15'(ack));
   endtask : t_i2c_addr
   task automatic t_i2c_write;
      logic [7:0] b[8] = '{8'h54, 8'h05, 8'h11, 8'h22, 8'h54, 8'h30, 8'h33, 8'h44};
      logic ack;
      logic ok = 1'h1;
      wr_q.delete();
      for (int i = 0; i < 8; i++)
      begin
         if (i % 4 == 0)
            u_host_model.i2c_start();
         u_host_model.i2c_byte(b[i], ack);
         ok &= ack;
      end
      u_host_model.i2c_stop();
      chk("acks", 15'h1, 15'(ok));
      chk("fifo", {7'h05, 8'h11, 7'h05, 8'h22}, {wr_q[0], wr_q[1]});
      chk("incr", {7'h30, 8'h33, 7'h31, 8'h44}, {wr_q[2], wr_q[3]});
   endtask : t_i2c_write
   task automatic t_i2c_read;
      logic a0, a1;
      logic [7:0] d0, d1;
      u_host_model.i2c_start();
      u_host_model.i2c_byte(8'h54, a0);
      u_host_model.i2c_byte(8'h40, a0);
      u_host_model.i2c_start();
      u_host_model.i2c_byte(8'h55, a1);
      u_host_model.i2c_read(1'h0, d0);
      u_host_model.i2c_read(1'h1, d1);
      u_host_model.i2c_stop();
      chk("rdack", 15'h3, {a0, a1});
      chk("rd", {rd_val(7'h40), rd_val(7'h41)}, {d0, d1});
      chk("release", 15'h1, 15'(sda_oe_n));
   endtask : t_i2c_read
   task automatic summarize;
      $display("Checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize
   initial
   begin
      read_trigger_pin = 1'h0;
      adr_pins = 2'h2;
      nv_adr = 2'h3;
      nv_adr_use = 1'h0;
      do_reset(host_port_pkg::IFSEL_UART);
      t_uart_write(8'h20, 8'h55, 1);
      t_uart_read(1'h1, 8'h21, {1'h1, rd_val(7'h10)}, 1);
      t_uart_read(1'h0, 8'h21, 9'h000, 0);
      t_uart_write(8'hFE, 8'h15, 0);
      u_host_model.bit_ns = 811;
      t_uart_read(1'h1, 8'hFF, 9'h115, 0);
      do_reset(host_port_pkg::IFSEL_I2C);
      t_i2c_addr(8'h00, 1'h0);
      t_i2c_addr(8'hF8, 1'h0);
      t_i2c_addr(8'h56, 1'h0);
      nv_adr_use = 1'h1;
      t_i2c_addr(8'h56, 1'h1);
      nv_adr_use = 1'h0;
      t_i2c_write();
      t_i2c_read();
      summarize();
   end
   // Whole run needs about 1 ms
   initial
   begin
      #4000000;
      error_cnt++;
      $display("Watchdog expired");
      summarize();
   end
endmodule : host_port_tb
`default_nettype wire
